//--- bench/cpu_model.sv
// cpu core model: takes each request, runs the routine a fixed time, nests two deep
module cpu_model #(
    parameter int HOLD = 40
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // controller side
    input  wire logic i_req,
    output logic      o_ack,
    output logic      o_ret,
    output logic      o_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] depth;
    int         cnt;
    assign o_busy = (depth != 2'h0);
    // acknowledge any request; a return pops the innermost routine HOLD+1 cycles after the ack pulse ends
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            o_ret <= 1'b0;
            depth <= 2'h0;
            cnt   <= 0;
        end else begin
            // one-cycle ack, never in the cycle after an ack or a return; an ack and a return can still land in the same cycle
            o_ack <= i_req && !o_ack && !o_ret;
            o_ret <= 1'b0;
            if (o_ack) begin
                depth <= depth + 2'h1;
                cnt   <= 0;
            end else if (depth != 2'h0) begin
                cnt <= cnt + 1;
                if (cnt == HOLD) begin
                    o_ret <= 1'b1;
                    depth <= depth - 2'h1;
                    cnt   <= 0;
                end
            end
        end
    end
endmodule : cpu_model

//--- bench/test_mcu_interrupt_vector_controller.sv
// self-checking bench for the interrupt vector controller
module test_mcu_interrupt_vector_controller import ivc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, cyc, stb, we, ack, req, lvl, iack, iret, busy;
    logic [7:0]  adr, page;
    logic [31:0] wdat, rdat, q;
    logic [15:0] vec;
    logic [12:0] flg, alt;
    logic [1:0]  clr;
    int          fails, checked;
    // pins are driven as the inverse of their flag bit: active low
    mcu_interrupt_vector_controller dut (
        .I_CLOCK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_EXT_REQ_ZERO_N(~flg[0]), .I_EXT_REQ_ONE_N(~flg[2]),
        .I_TMR0_OVERFLOW_FLAG(flg[1]), .I_TMR1_OVERFLOW_FLAG(flg[3]),
        .I_SERIAL0_RX_FLAG(flg[4]), .I_SERIAL0_TX_FLAG(alt[4]),
        .I_TMR2_OVERFLOW_FLAG(flg[5]), .I_TMR2_EXTERNAL_FLAG(alt[5]),
        .I_SPI_DONE_FLAG(flg[6]), .I_SPI_WRITE_COLLISION(alt[6]),
        .I_SPI_MODE_FAULT(alt[6]), .I_SPI_RX_OVERRUN(alt[6]), .I_SMB_EVENT_FLAG(flg[7]),
        .I_CONV_WINDOW_MATCH_FLAG(flg[8]), .I_PCA_OVERFLOW_FLAG(flg[9]),
        .I_PCA_MODULE_FLAG({6{alt[9]}}), .I_CMP0_FALL_FLAG(flg[10]),
        .I_CMP0_RISE_FLAG(flg[11]), .I_CMP1_FALL_FLAG(flg[12]),
        .O_TMR0_OVERFLOW_CLR(clr[0]), .O_TMR1_OVERFLOW_CLR(clr[1]),
        .I_INT_ACK(iack), .I_INT_RETURN(iret), .O_INT_REQ(req), .O_INT_VECTOR(vec),
        .O_INT_LEVEL(lvl), .O_REGISTER_PAGE(page));
    cpu_model #(.HOLD(40)) cpu (.i_clk(clk), .i_rst(rst), .i_req(req), .o_ack(iack),
        .o_ret(iret), .o_busy(busy));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task final_report;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait; a hang counts as a mismatch and ends the run
    task automatic wt(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v) begin
            @(posedge clk);
            n++;
            if (n > 300) begin
                fails++;
                final_report();
            end
        end
    endtask : wt
    // classic single wishbone cycle, request held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        @(posedge clk);
        wt(ack, 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task t_regs;
        chk(vec, 32'h0);
        wb(1'b0, 8'h1c, 8'h00);
        chk(q, 32'h0);
        wb(1'b1, OFS_TIMER_CTRL, 8'h05);
        wb(1'b0, OFS_TIMER_CTRL, 8'h00);
        chk(q, 32'h5);
        wb(1'b1, OFS_TIMER_CTRL, 8'h00);
    endtask : t_regs
    task t_vectors;
        logic [12:0] m;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 13; k++) begin
                m = 13'h0001 << k;
                wb(1'b1, OFS_BASE_EN, {2'b10, m[5:0]});
                wb(1'b1, OFS_EXT_EN, {1'b0, m[12:6]});
                // second pass raises the alternate flag of shared vectors
                alt <= (p == 1) ? m : 13'h0;
                flg <= (p == 1) ? (m & ~13'h0270) : m;
                wt(req, 1'b1);
                chk(vec, 32'h3 + 32'h8 * k);
                chk(page, (k == 12) ? 2 : (k > 9) ? 1 : 0);
                chk(lvl, 32'h0);
                wt(busy, 1'b1);
                chk(clr, (k == 1) ? 2'b01 : (k == 3) ? 2'b10 : 2'b00);
                // source holds until recognised, releases before the routine ends
                flg <= 13'h0;
                alt <= 13'h0;
                wt(busy, 1'b0);
                // give the return time to reach the controller before looking
                repeat (3) @(posedge clk);
                chk(req, 32'h0);
            end
        end
    endtask : t_vectors
    task t_prio;
        wb(1'b1, OFS_BASE_EN, 8'h8a);
        flg <= 13'h000a;
        wt(req, 1'b1);
        chk(vec, 32'h000b);
        wt(busy, 1'b1);
        flg <= 13'h0008;
        wb(1'b1, OFS_BASE_PRIO, 8'h08);
        wt(req, 1'b1);
        chk(vec, 32'h001b);
        chk(lvl, 32'h1);
        flg <= 13'h0;
        wt(busy, 1'b0);
        wb(1'b1, OFS_BASE_PRIO, 8'h00);
    endtask : t_prio
    task t_global;
        wb(1'b1, OFS_BASE_EN, 8'h02);
        flg <= 13'h0002;
        repeat (10) @(posedge clk);
        chk(req, 32'h0);
        wb(1'b0, OFS_PENDING, 8'h00);
        chk(q, 32'h2);
        wb(1'b1, OFS_BASE_EN, 8'h82);
        wt(req, 1'b1);
        wt(busy, 1'b1);
        flg <= 13'h0;
        wt(busy, 1'b0);
    endtask : t_global
    task t_edge;
        wb(1'b1, OFS_BASE_EN, 8'h00);
        wb(1'b1, OFS_TIMER_CTRL, 8'h05);
        flg <= 13'h0005;
        repeat (3) @(posedge clk);
        flg <= 13'h0;
        repeat (4) @(posedge clk);
        wb(1'b0, OFS_TIMER_CTRL, 8'h00);
        chk(q, 32'hf);
        wb(1'b1, OFS_BASE_EN, 8'h81);
        wt(req, 1'b1);
        wt(busy, 1'b1);
        wb(1'b0, OFS_TIMER_CTRL, 8'h00);
        chk(q, 32'hd);
        wt(busy, 1'b0);
        wb(1'b1, OFS_BASE_EN, 8'h00);
        wb(1'b1, OFS_TIMER_CTRL, 8'h00);
        flg <= 13'h0005;
        repeat (4) @(posedge clk);
        wb(1'b0, OFS_TIMER_CTRL, 8'h00);
        chk(q, 32'ha);
        flg <= 13'h0;
        repeat (4) @(posedge clk);
        wb(1'b0, OFS_TIMER_CTRL, 8'h00);
        chk(q, 32'h0);
    endtask : t_edge
    initial begin
        {rst, cyc, stb, we, adr, wdat, flg, alt} = {1'b1, 3'b000, 8'h00, 32'h0, 26'h0};
        fails = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_vectors();
        t_prio();
        t_global();
        t_edge();
        final_report();
    end
endmodule : test_mcu_interrupt_vector_controller

//--- design/ext_req_detect.sv
// one external request input: synchroniser, edge or level detect, pending flag
module ext_req_detect
    import ivc_pkg::*;
(
    // clock and reset
    input  logic i_clk,
    input  logic i_rst,
    // pin and mode
    input  logic i_req_n,
    input  logic i_edge_mode,
    // software and hardware flag access
    input  logic i_sw_wr,
    input  logic i_sw_val,
    input  logic i_hw_clr,
    // pending flag
    output logic o_pending
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic pend_ff;
    logic nxt_pend;
    logic fall_edge;

    // two flops against metastability, third flop only for edge history
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff  <= 1'b1;
        end else begin
            sync1_ff <= i_req_n;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // R1 active-low falling edge
    assign fall_edge = prev_ff & ~sync2_ff;

    // flag update; a fresh edge wins over any clear in the same cycle
    always_comb begin
        nxt_pend = pend_ff;
        // R3 clear on vectoring
        if (i_hw_clr) begin
            nxt_pend = 1'b0;
        end
        if (i_sw_wr) begin
            nxt_pend = i_sw_val;
        end
        nxt_pend = nxt_pend | fall_edge;
        // level mode keeps no latched state
        if (!i_edge_mode) begin
            nxt_pend = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // R4 level mode mirrors pin
    assign o_pending = i_edge_mode ? pend_ff : ~sync2_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_LEVEL_MIRROR: assert property (!i_edge_mode |-> o_pending == ~sync2_ff) // R4
        else $error("level mode pending does not follow the pin");
    AST_EDGE_CLEAR: assert property ( // R3
        (i_edge_mode && i_hw_clr && !fall_edge && !i_sw_wr) |=> (!i_edge_mode || !o_pending))
        else $error("edge pending not cleared on vectoring");
    AST_EDGE_SET_WINS: assert property ( // R1
        (i_edge_mode && $fell(sync2_ff)) |=> (!i_edge_mode || o_pending))
        else $error("falling edge lost");
    COV_EDGE_CAPTURE: cover property (i_edge_mode && fall_edge ##1 o_pending);

endmodule : ext_req_detect

//--- design/ivc_pkg.sv
// shared constants for the interrupt vector controller
package ivc_pkg;

    // number of vectored sources, index equals natural priority order
    localparam int unsigned NUM_SRC       = 13;
    localparam int unsigned PCA_MODULES   = 6;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE_EN    = 8'h04;
    localparam logic [7:0] OFS_BASE_PRIO  = 8'h08;
    localparam logic [7:0] OFS_EXT_EN     = 8'h0c;
    localparam logic [7:0] OFS_EXT_PRIO   = 8'h10;
    localparam logic [7:0] OFS_PENDING    = 8'h14;
    localparam logic [7:0] OFS_SERVICE    = 8'h18;

    // timer control field positions
    localparam int unsigned EXT0_EDGE_BIT = 0;
    localparam int unsigned EXT0_PEND_BIT = 1;
    localparam int unsigned EXT1_EDGE_BIT = 2;
    localparam int unsigned EXT1_PEND_BIT = 3;

    // global enable position in the base enable register
    localparam int unsigned GLOBAL_EN_BIT = 7;
    // sources below this index live in the base registers
    localparam int unsigned EXT_SRC_FIRST = 6;

    // reset values
    localparam logic [7:0]  RST_REG8      = 8'h00;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;

    // vector table: first maskable vector and spacing between vectors
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam logic [15:0] VEC_STEP      = 16'h0008;

    // source indices that carry special behaviour
    localparam logic [3:0]  SRC_EXT0      = 4'h0;
    localparam logic [3:0]  SRC_TMR0      = 4'h1;
    localparam logic [3:0]  SRC_EXT1      = 4'h2;
    localparam logic [3:0]  SRC_TMR1      = 4'h3;
    localparam logic [3:0]  SRC_CMP0_FALL = 4'ha;
    localparam logic [3:0]  SRC_CMP0_RISE = 4'hb;
    localparam logic [3:0]  SRC_CMP1_FALL = 4'hc;

    // register page of the flag sources
    localparam logic [7:0]  PAGE_BASE     = 8'h00;
    localparam logic [7:0]  PAGE_CMP0     = 8'h01;
    localparam logic [7:0]  PAGE_CMP1     = 8'h02;

endpackage : ivc_pkg

//--- design/mcu_interrupt_vector_controller.sv
// interrupt vectoring, priority and external request logic with wishbone registers
// Overview of operation
// R1 - external requests are active low; edge-select bits 0 and 2 pick level or edge
// R2 - pending flags for external inputs zero and one sit at bits 1 and 3
// R3 - edge-mode pending flag clears by hardware when the cpu vectors to it
// R4 - level-mode pending flag mirrors the input pin, no latching
// R5 - outside source holds a level request low until it is recognised
// R6 - outside source releases a level request before the routine ends
// R7 - reset vectors to 0x0000, always enabled, above every maskable source
// R8 - external zero vectors to 0x0003, order 0, enable and level bit 0
// R9 - external one vectors to 0x0013, order 2, enable and level bit 2
// R10 - timer overflows vector to 0x000b and 0x001b, flags cleared on vectoring
// R11 - serial port vectors to 0x0023, order 4, rx or tx, bit 4
// R12 - timer two vectors to 0x002b, order 5, overflow or external flag, bit 5
// R13 - spi vectors to 0x0033, order 6, any of four flags, extended bit 0
// R14 - two-wire bus vectors to 0x003b, order 7, extended bit 1
// R15 - window compare vectors to 0x0043, order 8, extended bit 2
// R16 - counter array vectors to 0x004b, order 9, overflow or module flag, bit 3
// R17 - comparator zero fall 0x0053 and rise 0x005b, extended bits 4, 5, page 1
// R18 - comparator one fall vectors to 0x0063, order 12, extended bit 6, page 2
// R19 - same level: lowest order first; high level pre-empts a low routine
// R20 - service needs own enable and global enable; vector to listed address
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
module mcu_interrupt_vector_controller
    import ivc_pkg::*;
(
    // clock and reset
    input  logic                   I_CLOCK,
    input  logic                   I_SYS_RST,
    // wishbone slave
    input  logic                   I_WB_CYC,
    input  logic                   I_WB_STB,
    input  logic                   I_WB_WE,
    input  logic [7:0]             I_WB_ADR,
    input  logic [3:0]             I_WB_SEL,
    input  logic [31:0]            I_WB_DAT,
    output logic [31:0]            O_WB_DAT,
    output logic                   O_WB_ACK,
    // external request pins
    input  logic                   I_EXT_REQ_ZERO_N,
    input  logic                   I_EXT_REQ_ONE_N,
    // peripheral event flags
    input  logic                   I_TMR0_OVERFLOW_FLAG,
    input  logic                   I_TMR1_OVERFLOW_FLAG,
    input  logic                   I_SERIAL0_RX_FLAG,
    input  logic                   I_SERIAL0_TX_FLAG,
    input  logic                   I_TMR2_OVERFLOW_FLAG,
    input  logic                   I_TMR2_EXTERNAL_FLAG,
    input  logic                   I_SPI_DONE_FLAG,
    input  logic                   I_SPI_WRITE_COLLISION,
    input  logic                   I_SPI_MODE_FAULT,
    input  logic                   I_SPI_RX_OVERRUN,
    input  logic                   I_SMB_EVENT_FLAG,
    input  logic                   I_CONV_WINDOW_MATCH_FLAG,
    input  logic                   I_PCA_OVERFLOW_FLAG,
    input  logic [PCA_MODULES-1:0] I_PCA_MODULE_FLAG,
    input  logic                   I_CMP0_FALL_FLAG,
    input  logic                   I_CMP0_RISE_FLAG,
    input  logic                   I_CMP1_FALL_FLAG,
    // timer flag clears
    output logic                   O_TMR0_OVERFLOW_CLR,
    output logic                   O_TMR1_OVERFLOW_CLR,
    // cpu core side
    input  logic                   I_INT_ACK,
    input  logic                   I_INT_RETURN,
    output logic                   O_INT_REQ,
    output logic [15:0]            O_INT_VECTOR,
    output logic                   O_INT_LEVEL,
    output logic [7:0]             O_REGISTER_PAGE
);

    // bus state
    logic                ack_ff;
    logic [31:0]         rdata_ff;
    logic [31:0]         nxt_rdata;
    logic                wb_hit;
    logic                wb_wr;
    // software registers
    logic [1:0]          edge_sel_ff;
    logic [7:0]          base_en_ff;
    logic [7:0]          base_prio_ff;
    logic [7:0]          ext_en_ff;
    logic [7:0]          ext_prio_ff;
    logic [1:0]          nxt_edge_sel;
    logic [7:0]          nxt_base_en;
    logic [7:0]          nxt_base_prio;
    logic [7:0]          nxt_ext_en;
    logic [7:0]          nxt_ext_prio;
    // sources
    logic [1:0]          ext_pend;
    logic [NUM_SRC-1:0]  src_pend;
    logic [NUM_SRC-1:0]  src_en;
    logic [NUM_SRC-1:0]  src_lvl;
    logic [NUM_SRC-1:0]  req_vec;
    logic [15:0]         en_all;
    logic [15:0]         prio_all;
    // service state
    logic                irq_ff;
    logic [3:0]          idx_ff;
    logic                level_ff;
    logic [15:0]         vec_ff;
    logic [7:0]          page_ff;
    logic                act_low_ff;
    logic                act_high_ff;
    logic                tmr0_clr_ff;
    logic                tmr1_clr_ff;
    logic                nxt_irq;
    logic [3:0]          nxt_idx;
    logic                nxt_level;
    logic [15:0]         nxt_vec;
    logic [7:0]          nxt_page;
    logic                nxt_act_low;
    logic                nxt_act_high;
    logic                ack_fire;
    logic                cand_hi;
    logic                cand_lo;
    logic [3:0]          idx_hi;
    logic [3:0]          idx_lo;

    // bus request seen once; ack drops the cycle after it is given
    assign wb_hit = I_WB_CYC & I_WB_STB & ~ack_ff;
    assign wb_wr  = wb_hit & I_WB_WE & I_WB_SEL[0];

    // register writes
    always_comb begin
        nxt_edge_sel  = edge_sel_ff;
        nxt_base_en   = base_en_ff;
        nxt_base_prio = base_prio_ff;
        nxt_ext_en    = ext_en_ff;
        nxt_ext_prio  = ext_prio_ff;
        if (wb_wr) begin
            unique case (I_WB_ADR)
                OFS_TIMER_CTRL: begin
                    // R1 detection type bits
                    nxt_edge_sel = {I_WB_DAT[EXT1_EDGE_BIT], I_WB_DAT[EXT0_EDGE_BIT]};
                end
                OFS_BASE_EN:   nxt_base_en   = I_WB_DAT[7:0];
                OFS_BASE_PRIO: nxt_base_prio = {1'b0, I_WB_DAT[6:0]};
                OFS_EXT_EN:    nxt_ext_en    = {1'b0, I_WB_DAT[6:0]};
                OFS_EXT_PRIO:  nxt_ext_prio  = {1'b0, I_WB_DAT[6:0]};
                default: ;
            endcase
        end
    end

    // register reads; unmapped offsets answer zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (I_WB_ADR)
            // R2 pending flags readable
            OFS_TIMER_CTRL: nxt_rdata[3:0] = {ext_pend[1], edge_sel_ff[1],
                                              ext_pend[0], edge_sel_ff[0]};
            OFS_BASE_EN:    nxt_rdata[7:0] = base_en_ff;
            OFS_BASE_PRIO:  nxt_rdata[7:0] = base_prio_ff;
            OFS_EXT_EN:     nxt_rdata[7:0] = ext_en_ff;
            OFS_EXT_PRIO:   nxt_rdata[7:0] = ext_prio_ff;
            OFS_PENDING:    nxt_rdata[NUM_SRC-1:0] = src_pend;
            OFS_SERVICE:    nxt_rdata[7:0] = {act_high_ff, act_low_ff, irq_ff,
                                              level_ff, idx_ff};
            default: ;
        endcase
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ack_ff       <= 1'b0;
            rdata_ff     <= 32'h0000_0000;
            edge_sel_ff  <= 2'h0;
            base_en_ff   <= RST_REG8;
            base_prio_ff <= RST_REG8;
            ext_en_ff    <= RST_REG8;
            ext_prio_ff  <= RST_REG8;
        end else begin
            ack_ff       <= wb_hit;
            rdata_ff     <= wb_hit ? nxt_rdata : rdata_ff;
            edge_sel_ff  <= nxt_edge_sel;
            base_en_ff   <= nxt_base_en;
            base_prio_ff <= nxt_base_prio;
            ext_en_ff    <= nxt_ext_en;
            ext_prio_ff  <= nxt_ext_prio;
        end
    end

    assign O_WB_ACK = ack_ff;
    assign O_WB_DAT = rdata_ff;

    assign ack_fire = I_INT_ACK & irq_ff;

    // R1 two active-low request inputs
    ext_req_detect u_ext0 (
        .i_clk       (I_CLOCK),
        .i_rst       (I_SYS_RST),
        .i_req_n     (I_EXT_REQ_ZERO_N),
        .i_edge_mode (edge_sel_ff[0]),
        .i_sw_wr     (wb_wr && I_WB_ADR == OFS_TIMER_CTRL),
        .i_sw_val    (I_WB_DAT[EXT0_PEND_BIT]),
        .i_hw_clr    (ack_fire && idx_ff == SRC_EXT0),
        .o_pending   (ext_pend[0])
    );

    ext_req_detect u_ext1 (
        .i_clk       (I_CLOCK),
        .i_rst       (I_SYS_RST),
        .i_req_n     (I_EXT_REQ_ONE_N),
        .i_edge_mode (edge_sel_ff[1]),
        .i_sw_wr     (wb_wr && I_WB_ADR == OFS_TIMER_CTRL),
        .i_sw_val    (I_WB_DAT[EXT1_PEND_BIT]),
        .i_hw_clr    (ack_fire && idx_ff == SRC_EXT1),
        .o_pending   (ext_pend[1])
    );

    // R8 R9 R10 R11 R12 source order
    // R13 R14 R15 R16 R17 R18 flag grouping; peripheral flags stay with software
    assign src_pend = {I_CMP1_FALL_FLAG,
                       I_CMP0_RISE_FLAG,
                       I_CMP0_FALL_FLAG,
                       I_PCA_OVERFLOW_FLAG | (|I_PCA_MODULE_FLAG),
                       I_CONV_WINDOW_MATCH_FLAG,
                       I_SMB_EVENT_FLAG,
                       I_SPI_DONE_FLAG | I_SPI_WRITE_COLLISION | I_SPI_MODE_FAULT
                           | I_SPI_RX_OVERRUN,
                       I_TMR2_OVERFLOW_FLAG | I_TMR2_EXTERNAL_FLAG,
                       I_SERIAL0_RX_FLAG | I_SERIAL0_TX_FLAG,
                       I_TMR1_OVERFLOW_FLAG,
                       ext_pend[1],
                       I_TMR0_OVERFLOW_FLAG,
                       ext_pend[0]};

    // base register holds the first six sources, extended the rest
    assign en_all   = {3'b000, ext_en_ff[6:0], base_en_ff[5:0]};
    assign prio_all = {3'b000, ext_prio_ff[6:0], base_prio_ff[5:0]};

    // R20 own enable and global enable
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            assign src_en[g]  = en_all[g];
            assign src_lvl[g] = prio_all[g];
            assign req_vec[g] = src_pend[g] & src_en[g] & base_en_ff[GLOBAL_EN_BIT];
        end
    endgenerate

    // R19 lowest order wins within a level; scan downward so index 0 lands last
    always_comb begin
        cand_hi = 1'b0;
        cand_lo = 1'b0;
        idx_hi  = 4'h0;
        idx_lo  = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req_vec[i] && src_lvl[i]) begin
                cand_hi = 1'b1;
                idx_hi  = 4'(i);
            end
            if (req_vec[i] && !src_lvl[i]) begin
                cand_lo = 1'b1;
                idx_lo  = 4'(i);
            end
        end
    end

    // selection and nesting; the request is held off in the ack cycle so the
    // cpu never sees a stale vector for a source it has just taken
    always_comb begin
        nxt_act_low  = act_low_ff;
        nxt_act_high = act_high_ff;
        // return pops the innermost level first
        if (I_INT_RETURN) begin
            if (act_high_ff) begin
                nxt_act_high = 1'b0;
            end else begin
                nxt_act_low = 1'b0;
            end
        end
        if (ack_fire) begin
            if (level_ff) begin
                nxt_act_high = 1'b1;
            end else begin
                nxt_act_low = 1'b1;
            end
        end
        nxt_irq   = 1'b0;
        nxt_idx   = idx_ff;
        nxt_level = level_ff;
        // R19 high level pre-empts low routine
        if (cand_hi && !nxt_act_high) begin
            nxt_irq   = !ack_fire;
            nxt_idx   = idx_hi;
            nxt_level = 1'b1;
        end else if (cand_lo && !nxt_act_high && !nxt_act_low) begin
            nxt_irq   = !ack_fire;
            nxt_idx   = idx_lo;
            nxt_level = 1'b0;
        end
        // R20 listed vector address
        nxt_vec  = nxt_irq ? 16'(VEC_BASE + VEC_STEP * 16'(nxt_idx)) : vec_ff;
        // R17 comparator register page
        if (nxt_idx == SRC_CMP0_FALL || nxt_idx == SRC_CMP0_RISE) begin
            nxt_page = PAGE_CMP0;
        end else if (nxt_idx == SRC_CMP1_FALL) begin
            // R18 comparator one page
            nxt_page = PAGE_CMP1;
        end else begin
            nxt_page = PAGE_BASE;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            irq_ff      <= 1'b0;
            idx_ff      <= 4'h0;
            level_ff    <= 1'b0;
            // R7 reset vector
            vec_ff      <= RESET_VECTOR;
            page_ff     <= PAGE_BASE;
            act_low_ff  <= 1'b0;
            act_high_ff <= 1'b0;
            tmr0_clr_ff <= 1'b0;
            tmr1_clr_ff <= 1'b0;
        end else begin
            irq_ff      <= nxt_irq;
            idx_ff      <= nxt_idx;
            level_ff    <= nxt_level;
            vec_ff      <= nxt_vec;
            page_ff     <= nxt_page;
            act_low_ff  <= nxt_act_low;
            act_high_ff <= nxt_act_high;
            // R10 timer flags cleared on vectoring
            tmr0_clr_ff <= ack_fire && idx_ff == SRC_TMR0;
            tmr1_clr_ff <= ack_fire && idx_ff == SRC_TMR1;
        end
    end

    assign O_INT_REQ           = irq_ff;
    assign O_INT_VECTOR        = vec_ff;
    assign O_INT_LEVEL         = level_ff;
    assign O_REGISTER_PAGE     = page_ff;
    assign O_TMR0_OVERFLOW_CLR = tmr0_clr_ff;
    assign O_TMR1_OVERFLOW_CLR = tmr1_clr_ff;

    // helper state read only by the checks below
    logic               seen_irq_ff;
    logic [NUM_SRC-1:0] req_q_ff;
    logic [NUM_SRC-1:0] lvl_q_ff;
    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            seen_irq_ff <= 1'b0;
            req_q_ff    <= '0;
            lvl_q_ff    <= '0;
        end else begin
            // follows the vector register, which moves on the same edge
            seen_irq_ff <= seen_irq_ff | nxt_irq;
            req_q_ff    <= req_vec;
            lvl_q_ff    <= src_lvl;
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    AST_RESET_VECTOR: assert property (!seen_irq_ff |-> O_INT_VECTOR == RESET_VECTOR) // R7
        else $error("vector left the reset address before any request");
    AST_VECTOR_ADDR: assert property ( // R20
        O_INT_REQ |-> O_INT_VECTOR == 16'(VEC_BASE + VEC_STEP * 16'(idx_ff)))
        else $error("vector address does not match the source order");
    AST_ENABLED_ONLY: assert property ($rose(O_INT_REQ) |-> req_q_ff[idx_ff]) // R20
        else $error("request raised for a disabled or idle source");
    AST_LOWEST_ORDER: assert property ( // R19
        O_INT_REQ |-> ((req_q_ff & (level_ff ? lvl_q_ff : ~lvl_q_ff)
                       & ((13'h1 << idx_ff) - 13'h1)) == 13'h0))
        else $error("a lower order request at the same level was passed over");
    AST_NESTING: assert property ( // R19
        O_INT_REQ |-> !act_high_ff && (level_ff || !act_low_ff))
        else $error("request offered that cannot pre-empt the active routine");
    AST_TMR0_CLEAR: assert property ( // R10
        (ack_fire && idx_ff == SRC_TMR0) |=> O_TMR0_OVERFLOW_CLR ##1 !O_TMR0_OVERFLOW_CLR)
        else $error("timer zero flag clear missing or too long");
    AST_CMP_PAGE: assert property ( // R17
        (O_INT_REQ && (idx_ff == SRC_CMP0_FALL || idx_ff == SRC_CMP0_RISE))
        |-> O_REGISTER_PAGE == PAGE_CMP0)
        else $error("comparator zero page wrong");
    AST_WB_ACK_PULSE: assert property ($rose(I_WB_CYC & I_WB_STB) |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("bus answer not a single cycle pulse one edge after request");

    COV_PREEMPT: cover property (act_low_ff && O_INT_REQ && O_INT_LEVEL);
    COV_EXT0_TAKEN: cover property (ack_fire && idx_ff == SRC_EXT0);
    COV_CMP1_VECTOR: cover property (O_INT_REQ && idx_ff == SRC_CMP1_FALL);

endmodule : mcu_interrupt_vector_controller
